// ===== rtl/fecs_ctrl.sv
// Host controller issuing flash erase sequences and polling status.
// Assumes a word- or byte-mode NOR flash on the pins, one clock at 200 MHz.
`timescale 1ns/1ps
module fecs_ctrl
  import fecs_pkg::*;
#(
  parameter int SEA_WAIT = SEA_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire fecs_op_e cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic cmd_last,
  input wire logic byte_mode,
  input wire logic hw_reset_req,
  input wire logic [DATA_W-1:0] dq_i,
  output logic cmd_ready_ff,
  output logic erase_done_ff,
  output logic erase_fail_ff,
  output logic window_open_ff,
  output logic suspended_ff,
  output logic [ADDR_W-1:0] flash_a_ff,
  output logic [DATA_W-1:0] flash_dq_o_ff,
  output logic flash_dq_oe_ff,
  output logic flash_we_n_ff,
  output logic flash_oe_n_ff,
  output logic flash_ce_n_ff,
  output logic flash_reset_n_ff
);
  initial
  begin
    if (SEA_WAIT < 1 || SEA_WAIT >= 2**CNT_W)
      $error("fecs_ctrl: SEA_WAIT out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_PREFIX, S_LAST, S_WINDOW, S_MORE, S_SUSP,
    S_POLL, S_POLL2, S_CHECK, S_RESET
  } fecs_state_e;

  fecs_state_e state_ff;
  logic [2:0] step_ff;
  logic [CNT_W-1:0] win_ff;
  logic [ADDR_W-1:0] sect_ff;
  logic chip_ff;
  logic [DATA_W-1:0] prev_ff;
  logic [DATA_W-1:0] dq_s1_ff;
  logic [DATA_W-1:0] dq_s2_ff;
  logic bc_start;
  logic bc_write;
  logic [ADDR_W-1:0] bc_addr;
  logic [DATA_W-1:0] bc_wdata;
  logic bc_busy;
  logic bc_done;
  logic [DATA_W-1:0] bc_rdata;
  logic [11:0] a1;
  logic [11:0] a2;

  // Pin data synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end
    else
    begin
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  assign a1 = byte_mode ? A_BYTE1 : A_WORD1;
  assign a2 = byte_mode ? A_BYTE2 : A_WORD2;

  // Bus request for the current step
  always_comb
  begin
    bc_start = 1'b0;
    bc_write = 1'b1;
    bc_addr = sect_ff;
    bc_wdata = D_SECTOR;
    unique case (state_ff)
      S_PREFIX:
      begin
        bc_start = !bc_busy && !bc_done;
        bc_addr = {{(ADDR_W-12){1'b0}}, (step_ff == 3'd1 ||
                   step_ff == 3'd4) ? a2 : a1};
        unique case (step_ff)
          3'd0, 3'd3: bc_wdata = D_UNLOCK1;
          3'd1, 3'd4: bc_wdata = D_UNLOCK2;
          default: bc_wdata = D_SETUP;
        endcase
      end
      S_LAST, S_MORE:
      begin
        bc_start = !bc_busy && !bc_done;
        if (chip_ff)
        begin
          bc_addr = {{(ADDR_W-12){1'b0}}, a1};
          bc_wdata = D_CHIP;
        end
      end
      S_SUSP:
      begin
        bc_start = !bc_busy && !bc_done;
        bc_wdata = D_SUSPEND;
      end
      S_POLL, S_POLL2:
      begin
        bc_start = !bc_busy && !bc_done;
        bc_write = 1'b0;
      end
      default: bc_start = 1'b0;
    endcase
  end

  // Sequence control
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= S_IDLE;
      step_ff <= '0;
      win_ff <= '0;
      sect_ff <= '0;
      chip_ff <= 1'b0;
      prev_ff <= '0;
      cmd_ready_ff <= 1'b0;
      erase_done_ff <= 1'b0;
      erase_fail_ff <= 1'b0;
      window_open_ff <= 1'b0;
      suspended_ff <= 1'b0;
      flash_reset_n_ff <= 1'b0;
    end
    else
    begin
      erase_done_ff <= 1'b0;
      erase_fail_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      if (hw_reset_req && state_ff != S_RESET)
      begin
        state_ff <= S_RESET;
        flash_reset_n_ff <= 1'b0;
        win_ff <= CNT_W'(RST_CYC);
        window_open_ff <= 1'b0;
        suspended_ff <= 1'b0;
      end
      else
      begin
        unique case (state_ff)
          S_IDLE:
          begin
            flash_reset_n_ff <= 1'b1;
            cmd_ready_ff <= 1'b1;
            if (cmd_valid && cmd_ready_ff && cmd_op != FECS_OP_SUSPEND)
            begin
              // Chip erase during run is never sent: commands are ignored
              chip_ff <= (cmd_op == FECS_OP_CHIP);
              sect_ff <= cmd_addr;
              step_ff <= '0;
              suspended_ff <= 1'b0;
              cmd_ready_ff <= 1'b0;
              state_ff <= S_PREFIX;
            end
          end
          S_PREFIX:
            if (bc_done)
            begin
              if (step_ff == 3'd4)
                state_ff <= S_LAST;
              step_ff <= step_ff + 3'd1;
            end
          S_LAST:
            if (bc_done)
            begin
              // Window starts at the strobe rising edge just issued
              win_ff <= CNT_W'(SEA_WAIT);
              window_open_ff <= !chip_ff;
              state_ff <= chip_ff ? S_POLL : S_WINDOW;
            end
          S_WINDOW:
          begin
            // Only sector adds or suspend go out inside the window
            cmd_ready_ff <= 1'b1;
            if (cmd_valid && cmd_ready_ff && cmd_op == FECS_OP_SECTOR &&
                win_ff != '0)
            begin
              sect_ff <= cmd_addr;
              cmd_ready_ff <= 1'b0;
              state_ff <= S_MORE;
            end
            else if (cmd_valid && cmd_ready_ff && cmd_op == FECS_OP_SUSPEND)
            begin
              cmd_ready_ff <= 1'b0;
              state_ff <= S_SUSP;
            end
            else if (win_ff == '0 || cmd_last)
            begin
              // Expired or cmd_last set: no late adds, outcome would be undefined
              window_open_ff <= 1'b0;
              cmd_ready_ff <= 1'b0;
              state_ff <= S_POLL;
            end
            else
              win_ff <= win_ff - 1'b1;
          end
          S_MORE:
            if (bc_done)
            begin
              win_ff <= CNT_W'(SEA_WAIT);
              state_ff <= S_WINDOW;
            end
          S_SUSP:
            if (bc_done)
            begin
              window_open_ff <= 1'b0;
              suspended_ff <= 1'b1;
              state_ff <= S_IDLE;
            end
          S_POLL:
            if (bc_done)
            begin
              prev_ff <= bc_rdata;
              state_ff <= S_POLL2;
            end
          S_POLL2:
            if (bc_done)
            begin
              // Last read is kept so the final check sees it
              prev_ff <= bc_rdata;
              if (bc_rdata[DQ_TOGGLE] != prev_ff[DQ_TOGGLE] ||
                  bc_rdata[DQ_ETOGGLE] != prev_ff[DQ_ETOGGLE] ||
                  !bc_rdata[DQ_POLL] || !prev_ff[DQ_POLL])
                state_ff <= S_POLL2;
              else
                state_ff <= S_CHECK;
            end
          S_CHECK:
          begin
            erase_done_ff <= (prev_ff == D_ERASED);
            erase_fail_ff <= (prev_ff != D_ERASED);
            state_ff <= S_IDLE;
          end
          S_RESET:
          begin
            // Drain a bus cycle cut by the reset before new commands
            if (win_ff == '0 && !bc_busy && !bc_done)
            begin
              flash_reset_n_ff <= 1'b1;
              state_ff <= S_IDLE;
            end
            else if (win_ff != '0)
              win_ff <= win_ff - 1'b1;
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  fecs_bus_cycle u_bus (
    .clk(clk),
    .rstn(rstn),
    .start(bc_start),
    .is_write(bc_write),
    .addr(bc_addr),
    .wdata(bc_wdata),
    .dq_sync(dq_s2_ff),
    .busy(bc_busy),
    .done(bc_done),
    .rdata(bc_rdata),
    .a_ff(flash_a_ff),
    .dq_o_ff(flash_dq_o_ff),
    .dq_oe_ff(flash_dq_oe_ff),
    .we_n_ff(flash_we_n_ff),
    .oe_n_ff(flash_oe_n_ff),
    .ce_n_ff(flash_ce_n_ff)
  );
endmodule

// ===== rtl/fecs_pkg.sv
// Constants for the flash erase sequencing host controller.
// Assumes a word- or byte-mode parallel NOR flash on the far side of the pins.
package fecs_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam logic [15:0] D_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] D_UNLOCK2 = 16'h0055;
  localparam logic [15:0] D_SETUP = 16'h0080;
  localparam logic [15:0] D_SECTOR = 16'h0030;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SUSPEND = 16'h00B0;
  localparam logic [15:0] D_ERASED = 16'hFFFF;
  localparam logic [11:0] A_WORD1 = 12'h555;
  localparam logic [11:0] A_WORD2 = 12'h2AA;
  localparam logic [11:0] A_BYTE1 = 12'hAAA;
  localparam logic [11:0] A_BYTE2 = 12'h555;
  localparam int DQ_POLL = 7;
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_WINDOW = 3;
  localparam int DQ_ETOGGLE = 2;
  // Bus cycle timing in clock cycles
  localparam int T_CLK_PS = 5000;
  localparam int T_WE_NS = 40;
  localparam int WE_CYC = (T_WE_NS * 1000 + T_CLK_PS - 1) / T_CLK_PS;
  localparam int T_RD_NS = 100;
  localparam int RD_CYC = (T_RD_NS * 1000 + T_CLK_PS - 1) / T_CLK_PS;
  // Sector accumulation window and the host's safety margin inside it
  localparam int SECTOR_ACCUMULATION_WINDOW_US = 50;
  localparam int SECTOR_ACCUMULATION_WINDOW_MARGIN_US = 40;
  localparam int SEA_CYC = (SECTOR_ACCUMULATION_WINDOW_MARGIN_US * 1000000) / T_CLK_PS;
  localparam int RST_CYC = 4;
  localparam int CNT_W = 16;
  typedef enum logic [1:0] {FECS_OP_SECTOR, FECS_OP_CHIP, FECS_OP_SUSPEND}
    fecs_op_e;
endpackage

// ===== rtl/fecs_bus_cycle.sv
// One write or read cycle on the flash pins with strobe timing.
// Assumes rdata pins already pass two flops before sampling here.
`timescale 1ns/1ps
module fecs_bus_cycle
  import fecs_pkg::*;
#(
  parameter int STROBE_CYC = WE_CYC,
  parameter int READ_CYC = RD_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] dq_sync,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [ADDR_W-1:0] a_ff,
  output logic [DATA_W-1:0] dq_o_ff,
  output logic dq_oe_ff,
  output logic we_n_ff,
  output logic oe_n_ff,
  output logic ce_n_ff
);
  initial
  begin
    if (STROBE_CYC < 1 || READ_CYC < 1 || READ_CYC + 2 >= 2**CNT_W)
      $error("fecs_bus_cycle: bad timing parameters");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic wr_ff;

  // Strobe phase counter
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_ff <= '0;
      wr_ff <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        wr_ff <= is_write;
        cnt_ff <= is_write ? CNT_W'(STROBE_CYC) : CNT_W'(READ_CYC + 2);
      end
      else if (busy)
      begin
        if (cnt_ff == '0)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // Pin drive; write data latches on the strobe rising edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      a_ff <= '0;
      dq_o_ff <= '0;
      dq_oe_ff <= 1'b0;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      ce_n_ff <= 1'b1;
      rdata <= '0;
    end
    else if (start && !busy)
    begin
      a_ff <= addr;
      dq_o_ff <= wdata;
      dq_oe_ff <= is_write;
      ce_n_ff <= 1'b0;
      we_n_ff <= !is_write;
      oe_n_ff <= is_write;
    end
    else if (busy && cnt_ff == '0)
    begin
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      ce_n_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      if (!wr_ff)
        rdata <= dq_sync;
    end
  end
endmodule

// ===== tb/fecs_ctrl_properties.sv
// Port checker for the flash erase host controller.
// Assumes binding onto fecs_ctrl at the foot of this file.
`timescale 1ns/1ps
module fecs_ctrl_properties
  import fecs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic hw_reset_req,
  input wire logic cmd_ready_ff,
  input wire logic erase_done_ff,
  input wire logic erase_fail_ff,
  input wire logic suspended_ff,
  input wire logic [ADDR_W-1:0] flash_a_ff,
  input wire logic flash_dq_oe_ff,
  input wire logic flash_we_n_ff,
  input wire logic flash_oe_n_ff,
  input wire logic flash_ce_n_ff,
  input wire logic flash_reset_n_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  we_ce_a: assert property (!flash_we_n_ff |-> !flash_ce_n_ff)
    else $error("write strobe without select");
  we_drive_a: assert property (!flash_we_n_ff |->
    flash_dq_oe_ff && flash_oe_n_ff) else $error("write not driving");
  we_width_a: assert property ($fell(flash_we_n_ff) |->
    !flash_we_n_ff[*8]) else $error("write strobe too short");
  addr_hold_a: assert property (!flash_we_n_ff &&
    $past(!flash_we_n_ff) |-> $stable(flash_a_ff))
    else $error("address moved in strobe");
  end_pulse_a: assert property (erase_done_ff || erase_fail_ff |=>
    !erase_done_ff && !erase_fail_ff) else $error("end flag too long");
  take_drop_a: assert property (cmd_valid && cmd_ready_ff |=>
    !cmd_ready_ff) else $error("ready held after take");
  rst_abort_a: assert property (hw_reset_req |->
    ##[1:40] !flash_reset_n_ff) else $error("no flash reset");
  rst_width_a: assert property ($fell(flash_reset_n_ff) |->
    !flash_reset_n_ff[*4]) else $error("flash reset too short");
  cover property (erase_done_ff);
  cover property (erase_fail_ff);
  cover property ($rose(suspended_ff));
endmodule

bind fecs_ctrl fecs_ctrl_properties chk_i (.clk, .rstn, .cmd_valid,
  .hw_reset_req, .cmd_ready_ff, .erase_done_ff, .erase_fail_ff,
  .suspended_ff, .flash_a_ff, .flash_dq_oe_ff, .flash_we_n_ff,
  .flash_oe_n_ff, .flash_ce_n_ff, .flash_reset_n_ff);

// ===== tb/fecs_flash_model.sv
// Behavioural NOR flash: erase command decoder and status reads.
// Assumes host strobes registered on the same clock.
`timescale 1ns/1ps
module fecs_flash_model
  import fecs_pkg::*;
#(
  parameter int WIN = 60,
  parameter int ERS = 200
)
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] a,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic ce_n,
  input wire logic reset_n,
  input wire logic byte_mode,
  input wire logic bad,
  output logic [DATA_W-1:0] dq
);
  logic wl, oq, tg, chip;
  logic [2:0] st, step;
  logic [ADDR_W-1:0] la, sec_a;
  logic [DATA_W-1:0] ld, rv, ed;
  logic [11:0] a1, a2, ex;
  int tmr, nsec;
  assign a1 = byte_mode ? A_BYTE1 : A_WORD1;
  assign a2 = byte_mode ? A_BYTE2 : A_WORD2;
  assign ex = (step == 1 || step == 4) ? a2 : a1;
  assign ed = step == 2 ? D_SETUP :
    (step == 1 || step == 4) ? D_UNLOCK2 : D_UNLOCK1;
  assign rv = st == 0 ? (bad ? 16'hFFFE : D_ERASED) :
    {8'h00, st == 4, tg, 2'b00, st == 2 || st == 3, tg, 2'b00};
  assign dq = (!oe_n && !ce_n) ? rv : ~rv;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= 0;
      step <= 0;
      wl <= 0;
      oq <= 1;
      tg <= 0;
      chip <= 0;
      nsec <= 0;
      tmr <= 0;
    end
    else
    begin
      wl <= !we_n && !ce_n;
      oq <= oe_n;
      tg <= tg ^ (oq && !oe_n);
      tmr <= tmr + 1;
      if (!we_n)
      begin
        la <= a;
        ld <= dq_o;
      end
      if (wl && we_n)
      begin
        if (st == 0 && step < 5)
          step <= (la[11:0] == ex && ld == ed) ? step + 1 : 0;
        else if (st == 0)
        begin
          step <= 0;
          tmr <= 0;
          sec_a <= la;
          nsec <= 1;
          if (ld == D_SECTOR)
            st <= 1;
          if (ld == D_CHIP && la[11:0] == a1)
          begin
            st <= 3;
            chip <= 1'b1;
          end
        end
        else if (st == 1 && ld == D_SECTOR)
        begin
          tmr <= 0;
          nsec <= nsec + 1;
          sec_a <= la;
        end
        else if (ld == D_SUSPEND && st < 3)
          st <= 4;
        else if (st == 1)
          st <= 0;
      end
      else if (st == 1 && tmr >= WIN)
      begin
        st <= 2;
        tmr <= 0;
      end
      else if ((st == 2 || st == 3) && tmr >= ERS)
        st <= 0;
    end
  end
endmodule

// ===== tb/fecs_ctrl_tb.sv
// Self-checking bench for the flash erase host controller.
// Assumes the flash model on the pins and the bound checker.
`timescale 1ns/1ps
module fecs_ctrl_tb
  import fecs_pkg::*;
;
  logic clk, rstn, cmd_valid, cmd_last, byte_mode, hw_reset_req, bad;
  fecs_op_e cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_a_ff;
  logic [DATA_W-1:0] dq_i, flash_dq_o_ff;
  logic cmd_ready_ff, erase_done_ff, erase_fail_ff, window_open_ff;
  logic suspended_ff, flash_dq_oe_ff, flash_we_n_ff, flash_oe_n_ff;
  logic flash_ce_n_ff, flash_reset_n_ff;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  fecs_ctrl #(.SEA_WAIT(20)) fecs_ctrl_i (.clk, .rstn, .cmd_valid,
    .cmd_op, .cmd_addr, .cmd_last, .byte_mode, .hw_reset_req, .dq_i,
    .cmd_ready_ff, .erase_done_ff, .erase_fail_ff, .window_open_ff,
    .suspended_ff, .flash_a_ff, .flash_dq_o_ff, .flash_dq_oe_ff,
    .flash_we_n_ff, .flash_oe_n_ff, .flash_ce_n_ff, .flash_reset_n_ff);
  fecs_flash_model #(.WIN(60), .ERS(200)) fecs_flash_model_i (.clk,
    .a(flash_a_ff), .dq_o(flash_dq_o_ff), .we_n(flash_we_n_ff),
    .oe_n(flash_oe_n_ff), .ce_n(flash_ce_n_ff),
    .reset_n(flash_reset_n_ff), .byte_mode, .bad, .dq(dq_i));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  task close_out;
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_lv(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 3000)
    begin
      n++;
      @(negedge clk);
    end
    chk(s, v);
  endtask
  task send(input fecs_op_e op, input logic [ADDR_W-1:0] ad);
    cmd_op = op;
    cmd_addr = ad;
    cmd_valid = 1'b1;
    wait_lv(cmd_ready_ff, 1'b1);
    @(negedge clk);
    cmd_valid = 1'b0;
    @(negedge clk);
  endtask
  task wait_end(input logic ed, input logic ef);
    int n;
    n = 0;
    while (!(erase_done_ff || erase_fail_ff) && n < 5000)
    begin
      n++;
      @(negedge clk);
    end
    chk({erase_done_ff, erase_fail_ff}, {ed, ef});
  endtask
  task hw_pulse;
    hw_reset_req = 1'b1;
    @(negedge clk);
    hw_reset_req = 1'b0;
    wait_lv(flash_reset_n_ff, 1'b0);
    wait_lv(flash_reset_n_ff, 1'b1);
    chk(fecs_flash_model_i.st, 0);
  endtask
  task t_sector;
    send(FECS_OP_SECTOR, 26'h0030000);
    send(FECS_OP_SECTOR, 26'h0010000);
    cmd_last = 1'b1;
    wait_end(1'b1, 1'b0);
    chk(fecs_flash_model_i.nsec, 2);
    chk(fecs_flash_model_i.sec_a, 26'h0010000);
    cmd_last = 1'b0;
  endtask
  task t_chip(input logic bm, input logic bd);
    byte_mode = bm;
    bad = bd;
    send(FECS_OP_CHIP, '0);
    wait_end(!bd, bd);
    chk(fecs_flash_model_i.chip, 1);
    byte_mode = 1'b0;
    bad = 1'b0;
  endtask
  task t_susp;
    send(FECS_OP_SECTOR, 26'h0020000);
    wait_lv(window_open_ff, 1'b1);
    send(FECS_OP_SUSPEND, '0);
    wait_lv(suspended_ff, 1'b1);
    chk(fecs_flash_model_i.st, 4);
  endtask
  task t_reset;
    int n;
    hw_pulse;
    cmd_last = 1'b1;
    send(FECS_OP_SECTOR, 26'h0040000);
    n = 0;
    while (fecs_flash_model_i.st != 2 && n < 3000)
    begin
      n++;
      @(negedge clk);
    end
    hw_pulse;
    send(FECS_OP_SECTOR, 26'h0040000);
    wait_end(1'b1, 1'b0);
    chk(fecs_flash_model_i.nsec, 1);
    cmd_last = 1'b0;
  endtask
  initial
  begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = FECS_OP_SECTOR;
    cmd_addr = '0;
    cmd_last = 1'b0;
    byte_mode = 1'b0;
    hw_reset_req = 1'b0;
    bad = 1'b0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_sector;
    t_chip(1'b1, 1'b0);
    t_chip(1'b0, 1'b1);
    t_susp;
    t_reset;
    close_out;
  end
endmodule
